/* File: logic/dac_ctrl_map.svh */
`ifndef DAC_CTRL_MAP_SVH
`define DAC_CTRL_MAP_SVH

// Channel count
`define NUM_CH 8

// Field positions in the 24-bit command word
`define WORD_W 24
`define OPC_MSB 23
`define OPC_LSB 20
`define ADDR_MSB 19
`define ADDR_LSB 16
`define CFG_RD_BIT 0
`define CFG_TS_BIT 1

// Command opcodes
`define OP_PD_CHAN 4'h4
`define OP_PD_CHIP 4'h5
`define OP_CONFIG 4'h7
`define OP_UPDATE_ALL 4'h9

// Reset values
`define RST_REF_DISABLE 1'b0
`define RST_TS_DISABLE 1'b0

// Cycles waited after reset before the reference strap is sampled
`define STRAP_WAIT 2'h3

// Idle levels of the synchronised inputs {load_n, cs, hot, cooled, ref_comp}
`define PIN_IDLE 5'h1b

`endif

/* File: logic/dac_ctrl_pkg.sv */
`include "dac_ctrl_map.svh"

package dac_ctrl_pkg;

  // Command opcodes of interest to this block
  typedef enum logic [3:0] {
    CMD_PD_CHAN = `OP_PD_CHAN,
    CMD_PD_CHIP = `OP_PD_CHIP,
    CMD_CONFIG = `OP_CONFIG,
    CMD_UPDATE_ALL = `OP_UPDATE_ALL
  } cmd_e;

  // Whole state of the control block
  typedef struct packed {
    logic ld_prev;
    logic cs_prev;
    logic hot_prev;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic ref_strap_ext;
    logic ref_disable;
    logic ts_disable;
    logic [`NUM_CH-1:0] chan_pd;
    logic chip_pd;
    logic shutdown;
    logic flag;
    logic [`NUM_CH-1:0] dac_load;
    logic [`NUM_CH-1:0] chan_en;
    logic ref_en;
    logic cmd_exec;
    logic cmd_inhibit;
  } state_s;

endpackage

/* File: logic/sync_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Raw pin levels in, synchronised levels out
interface sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport sink (input raw, output sync);
endinterface

`default_nettype wire

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pins in, synchronised levels out
  sync_if.sink port
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;

  // Two flops; only the second stage is read outside
  always_comb
  begin
    d.meta = port.raw;
    d.stable = q.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign port.sync = q.stable;

endmodule // pin_sync

`default_nettype wire

/* File: logic/dac_async_load_thermal_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_map.svh"

module dac_async_load_thermal_ctrl
  import dac_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host pins
  input wire logic async_load_n,
  input wire logic chip_select_load,
  // Analog status and strap
  input wire logic die_over_limit,
  input wire logic die_cooled,
  input wire logic ref_comp_pin,
  // Received word and extra updates from the serial decoder
  input wire logic [`WORD_W-1:0] rx_word,
  input wire logic update_req,
  // Channel and reference control
  output logic [`NUM_CH-1:0] dac_load,
  output logic [`NUM_CH-1:0] chan_out_en,
  output logic ref_out_en,
  output logic ref_disable,
  output logic thermal_protect_disable_bit,
  // Command status
  output logic cmd_exec,
  output logic cmd_inhibit,
  // Open-drain over-temperature flag
  output logic overtemp_flag_n_o,
  output logic overtemp_flag_n_oe
);

  localparam state_s RST_STATE = '{
    ld_prev: 1'b1, cs_prev: 1'b1, hot_prev: 1'b0, strap_cnt: 2'h0, strap_done: 1'b0,
    ref_strap_ext: 1'b0, ref_disable: `RST_REF_DISABLE, ts_disable: `RST_TS_DISABLE,
    chan_pd: '0, chip_pd: 1'b0, shutdown: 1'b0, flag: 1'b0, dac_load: '0, chan_en: '0,
    ref_en: 1'b0, cmd_exec: 1'b0, cmd_inhibit: 1'b0
  };

  state_s q;
  state_s d;
  logic s_ld, s_cs, s_hot, s_cool, s_ref;
  logic ld_low, ld_fall, cs_rise, trip, upd, inh;
  logic [3:0] opc;
  logic [3:0] addr;

  sync_if #(.W(5)) pins ();

  // Pin synchronisers
  assign pins.raw = {async_load_n, chip_select_load, die_over_limit, die_cooled, ref_comp_pin};
  pin_sync #(.W(5), .RST_VAL(`PIN_IDLE)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port(pins)
  );
  assign {s_ld, s_cs, s_hot, s_cool, s_ref} = pins.sync;

  assign opc = rx_word[`OPC_MSB:`OPC_LSB];
  assign addr = rx_word[`ADDR_MSB:`ADDR_LSB];

  // Next-state logic
  always_comb
  begin
    d = q;
    d.dac_load = '0;
    d.cmd_exec = 1'b0;
    d.cmd_inhibit = 1'b0;
    ld_low = ~s_ld;
    ld_fall = q.ld_prev & ~s_ld;
    cs_rise = ~q.cs_prev & s_cs & q.strap_done;
    trip = s_hot & ~q.hot_prev;
    upd = update_req;
    inh = 1'b0;
    d.ld_prev = s_ld;
    d.cs_prev = s_cs;
    d.hot_prev = s_hot;
    // Strap sampled once the synchroniser holds the real pin level
    if (!q.strap_done)
    begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == `STRAP_WAIT)
      begin
        d.strap_done = 1'b1;
        d.ref_strap_ext = ~s_ref;
      end
    end
    // Load edge powers up; updates only outside a frame
    if (ld_fall)
    begin
      d.chan_pd = '0;
      d.chip_pd = 1'b0;
      if (s_cs)
      begin
        d.dac_load = '1;
        upd = 1'b1;
      end
    end
    // End of frame: run the received command
    if (cs_rise)
    begin
      d.flag = 1'b0;
      d.cmd_exec = 1'b1;
      inh = ld_low & (opc == `OP_PD_CHAN || opc == `OP_PD_CHIP || opc == `OP_CONFIG);
      d.cmd_inhibit = inh;
      if (!inh)
      begin
        case (cmd_e'(opc))
          CMD_PD_CHAN:
          begin
            if (addr < 4'(`NUM_CH))
            begin
              d.chan_pd[addr[2:0]] = 1'b1;
            end
          end
          CMD_PD_CHIP:
          begin
            d.chan_pd = '1;
            d.chip_pd = 1'b1;
          end
          CMD_CONFIG:
          begin
            d.ref_disable = rx_word[`CFG_RD_BIT];
            d.ts_disable = rx_word[`CFG_TS_BIT];
          end
          CMD_UPDATE_ALL:
          begin
            d.dac_load = '1;
            d.chan_pd = '0;
            d.chip_pd = 1'b0;
            upd = 1'b1;
          end
          default:
          begin
          end
        endcase
      end
      if (ld_low)
      begin
        d.dac_load = '1;
        d.chan_pd = '0;
        d.chip_pd = 1'b0;
        upd = 1'b1;
      end
    end
    // Latched thermal shutdown; a hot die with protection enabled wins over any clear
    if (upd && s_cool)
    begin
      d.shutdown = 1'b0;
    end
    if (s_hot && !q.ts_disable)
    begin
      d.shutdown = 1'b1;
    end
    if (trip)
    begin
      d.flag = 1'b1;
    end
    // Shutdown gates channels only, never the reference
    d.chan_en = ~d.chan_pd & ~{`NUM_CH{d.shutdown}};
    d.ref_en = ~d.ref_disable & ~d.ref_strap_ext & ~d.chip_pd & d.strap_done;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q <= RST_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register, except the constant flag level
  assign dac_load = q.dac_load;
  assign chan_out_en = q.chan_en;
  assign ref_out_en = q.ref_en;
  assign ref_disable = q.ref_disable;
  assign thermal_protect_disable_bit = q.ts_disable;
  assign cmd_exec = q.cmd_exec;
  assign cmd_inhibit = q.cmd_inhibit;
  assign overtemp_flag_n_o = 1'b0; // Open drain only ever pulls low
  assign overtemp_flag_n_oe = q.flag;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_load_outside_frame;
    ld_fall && s_cs |=> dac_load == '1 ##1 dac_load == '0;
  endproperty
  a_load_outside_frame: assert property (p_load_outside_frame) else $error("load pin did not update all");

  property p_no_load_in_frame;
    ld_fall && !s_cs |=> dac_load == '0;
  endproperty
  a_no_load_in_frame: assert property (p_no_load_in_frame) else $error("load pulse in frame updated");

  property p_load_at_rise;
    cs_rise && ld_low |=> cmd_exec && dac_load == '1;
  endproperty
  a_load_at_rise: assert property (p_load_at_rise) else $error("late load did not execute and update");

  property p_powerup;
    ld_fall && !q.shutdown && !s_hot && !cs_rise |=> chan_out_en == '1;
  endproperty
  a_powerup: assert property (p_powerup) else $error("load pin did not power up");

  property p_inhibit;
    cs_rise && ld_low && opc == `OP_CONFIG |=> cmd_inhibit && $stable(ref_disable) && $stable(thermal_protect_disable_bit);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("config not inhibited");

  property p_config;
    cs_rise && !ld_low && opc == `OP_CONFIG |=> ref_disable == $past(rx_word[`CFG_RD_BIT]);
  endproperty
  a_config: assert property (p_config) else $error("reference disable not written");

  property p_strap;
    q.ref_strap_ext |-> !ref_out_en;
  endproperty
  a_strap: assert property (p_strap) else $error("reference on despite strap");

  property p_trip;
    s_hot && !q.ts_disable |=> chan_out_en == '0;
  endproperty
  a_trip: assert property (p_trip) else $error("channels on while hot");

  property p_ref_kept;
    q.strap_done && s_hot && !cs_rise && !ld_fall |=> ref_out_en == $past(ref_out_en);
  endproperty
  a_ref_kept: assert property (p_ref_kept) else $error("reference changed by heat");

  property p_latch;
    q.shutdown && !(upd && s_cool) |=> q.shutdown;
  endproperty
  a_latch: assert property (p_latch) else $error("shutdown cleared without update");

  property p_clear;
    q.shutdown && upd && s_cool && !s_hot |=> !q.shutdown;
  endproperty
  a_clear: assert property (p_clear) else $error("update did not clear shutdown");

  property p_release;
    cs_rise && !trip |=> !overtemp_flag_n_oe;
  endproperty
  a_release: assert property (p_release) else $error("flag not released");

  property p_ts_off;
    q.ts_disable && !q.shutdown |=> !q.shutdown;
  endproperty
  a_ts_off: assert property (p_ts_off) else $error("shutdown while protection off");

  property p_pd_chan;
    cs_rise && !ld_low && opc == `OP_PD_CHAN && addr < 4'(`NUM_CH) |=> !chan_out_en[$past(addr[2:0])];
  endproperty
  a_pd_chan: assert property (p_pd_chan) else $error("channel not powered down");

  c_load_outside: cover property (ld_fall && s_cs);
  c_late_load: cover property (cs_rise && ld_low);
  c_trip_clear: cover property (q.shutdown ##[1:50] !q.shutdown);
  c_inhibited: cover property (cmd_inhibit);

endmodule // dac_async_load_thermal_ctrl

`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_map.svh"

module host_model (
  // Clock
  input wire logic sys_clk,
  // Host pins
  output logic async_load_n,
  output logic chip_select_load,
  output logic [`WORD_W-1:0] rx_word
);
  // Idle pins at time zero
  initial
  begin
    async_load_n = 1'b1;
    chip_select_load = 1'b1;
    rx_word = '0;
  end

  // Idle cycles, counted at the falling edge
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Load pulse outside a frame, long enough to be synchronised
  task automatic ld_pulse();
    async_load_n = 1'b0;
    idle(4);
    async_load_n = 1'b1;
    idle(4);
  endtask

  // Frame; mode 1 pulses load inside it, mode 2 keeps load low past the rise
  task automatic frame(input logic [`WORD_W-1:0] w, input int mode);
    chip_select_load = 1'b0;
    idle(4);
    async_load_n = (mode == 0); // Low for both load modes
    idle(4);
    async_load_n = (mode != 2); // Pulse ends inside the frame
    idle(4);
    rx_word = w;
    chip_select_load = 1'b1;
    idle(5);
    async_load_n = 1'b1;
    rx_word = ~w; // Word no longer held
    idle(4);
  endtask
endmodule // host_model

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_ctrl_map.svh"

module testbench;
  logic sys_clk, rst_n, die_over_limit, die_cooled, ref_comp_pin, update_req;
  logic async_load_n, chip_select_load, ref_out_en, ref_disable, ts_bit;
  logic cmd_exec, cmd_inhibit, flag_o, flag_oe;
  logic [`WORD_W-1:0] rx_word;
  logic [7:0] dac_load, chan;
  logic [7:0] seen_ld;
  logic seen_ex, seen_inh;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [3:0] ops [4] = '{4'h4, 4'h5, 4'h7, 4'hf};

  // Device under test and host partner
  dac_async_load_thermal_ctrl dac_async_load_thermal_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .async_load_n(async_load_n), .chip_select_load(chip_select_load), .die_over_limit(die_over_limit),
    .die_cooled(die_cooled), .ref_comp_pin(ref_comp_pin), .rx_word(rx_word), .update_req(update_req),
    .dac_load(dac_load), .chan_out_en(chan), .ref_out_en(ref_out_en), .ref_disable(ref_disable),
    .thermal_protect_disable_bit(ts_bit), .cmd_exec(cmd_exec), .cmd_inhibit(cmd_inhibit),
    .overtemp_flag_n_o(flag_o), .overtemp_flag_n_oe(flag_oe));
  host_model host_model_i (.sys_clk(sys_clk), .async_load_n(async_load_n),
    .chip_select_load(chip_select_load), .rx_word(rx_word));

  // Clock
  always #50 sys_clk = ~sys_clk;

  // Catch one-cycle pulses
  always @(posedge sys_clk)
  begin
    if (dac_load != 8'h00)
      seen_ld <= dac_load;
    if (cmd_exec === 1'b1)
      seen_inh <= cmd_inhibit;
    seen_ex <= seen_ex | cmd_exec;
  end

  // Status pins and update strobe, set per scenario step
  task automatic set_env(input logic hot, input logic cool, input logic upd);
    die_over_limit = hot;
    die_cooled = cool;
    update_req = upd;
  endtask

  task automatic clr();
    seen_ld = 8'h00;
    seen_ex = 1'b0;
    seen_inh = 1'b0;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    chk1(ref_disable, 1'b0);
    chk1(ts_bit, 1'b0);
    chk1(ref_out_en, 1'b1);
    chk1(flag_oe, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_load();
    clr();
    host_model_i.ld_pulse();
    chk8(seen_ld, 8'hff);
    chk8(chan, 8'hff);
    $display("test load done");
  endtask

  task automatic t_pd();
    host_model_i.frame(24'h430000, 0);
    chk8(chan, 8'hf7);
    host_model_i.frame(24'h490000, 0);
    chk8(chan, 8'hf7);
    host_model_i.frame(24'h500000, 0);
    chk8(chan, 8'h00);
    clr();
    host_model_i.frame(24'hf00000, 1);
    chk8(chan, 8'hff);
    chk8(seen_ld, 8'h00);
    $display("test power-down done");
  endtask

  task automatic t_late();
    foreach (ops[i])
    begin
      clr();
      host_model_i.frame({ops[i], 4'h3, 16'h0001}, 2);
      chk1(seen_ex, 1'b1);
      chk8(seen_ld, 8'hff);
      chk1(seen_inh, ops[i] != 4'hf);
      chk8(chan, 8'hff);
      chk1(ref_disable, 1'b0);
    end
    $display("test late load done");
  endtask

  task automatic t_cfg();
    host_model_i.frame(24'h700001, 0);
    chk1(ref_disable, 1'b1);
    host_model_i.frame(24'h700000, 0);
    chk1(ref_disable, 1'b0);
    $display("test config done");
  endtask

  task automatic t_hot();
    host_model_i.ld_pulse();
    set_env(1'b1, 1'b0, 1'b0);
    host_model_i.idle(5);
    chk8(chan, 8'h00);
    chk1(flag_oe, 1'b1);
    chk1(flag_o, 1'b0);
    chk1(ref_out_en, 1'b1);
    set_env(1'b0, 1'b0, 1'b1);
    host_model_i.idle(1);
    set_env(1'b0, 1'b0, 1'b0);
    host_model_i.frame(24'hf00000, 0);
    chk8(chan, 8'h00);
    chk1(flag_oe, 1'b0);
    set_env(1'b0, 1'b1, 1'b0);
    host_model_i.idle(4);
    set_env(1'b0, 1'b1, 1'b1);
    host_model_i.idle(1);
    set_env(1'b0, 1'b1, 1'b0);
    host_model_i.idle(4);
    chk8(chan, 8'hff);
    set_env(1'b0, 1'b0, 1'b0);
    $display("test thermal done");
  endtask

  task automatic t_ts();
    host_model_i.frame(24'h700002, 0);
    chk1(ts_bit, 1'b1);
    set_env(1'b1, 1'b0, 1'b0);
    host_model_i.idle(5);
    chk8(chan, 8'hff);
    set_env(1'b0, 1'b0, 1'b0);
    host_model_i.frame(24'h700000, 0);
    chk1(ts_bit, 1'b0);
    $display("test thermal disable done");
  endtask

  task automatic t_strap(input logic strap);
    ref_comp_pin = strap;
    rst_n = 1'b0;
    host_model_i.idle(4);
    rst_n = 1'b1;
    host_model_i.idle(8);
    chk1(ref_out_en, strap);
    $display("test strap done");
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    set_env(1'b0, 1'b0, 1'b0);
    ref_comp_pin = 1'b1;
    clr();
    host_model_i.idle(4);
    rst_n = 1'b1;
    host_model_i.idle(8);
    t_reset();
    t_load();
    t_pd();
    t_late();
    t_cfg();
    t_hot();
    t_ts();
    t_strap(1'b0);
    t_strap(1'b1);
    final_report();
  end

  // Watchdog
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
endmodule // testbench

`default_nettype wire
